// [ts_stream_in_out_port.v]
// stream input port, pid selection and restamping stream output port
// assumes REF_CLK 100 MHz, link pins asynchronous, register master on REF_CLK
`timescale 1ns/100ps
`include "ts_port_regs.vh"
module ts_stream_in_out_port #(
  parameter       NUM_PID  = 64,
  parameter [0:0] UNIT_ID  = 1'b0,
  parameter [3:0] OUT_HALF = 4'h2
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire [11:0] ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  input  wire        IN_LINK_CLOCK,
  input  wire        IN_PACKET_START,
  input  wire        IN_BYTE_QUALIFIER,
  input  wire [7:0]  IN_DATA,
  output reg         OUT_CLOCK,
  output reg         OUT_PACKET_START,
  output reg         OUT_BYTE_QUALIFIER,
  output reg  [7:0]  OUT_DATA
);
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  reg [`CTRL_W-1:0] ctrl;
  reg [`PID_W-1:0]  pid_tab [0:NUM_PID-1];
  reg [7:0]         mem [0:2*`PKT_LEN9-1];
  reg [`CNT_W-1:0]  rx_cnt;
  reg [`CNT_W-1:0]  tx_cnt;
  reg [`CNT_W-1:0]  drop_cnt;
  reg [`CNT_W-1:0]  scr_cnt;
  integer           i;
  integer           j;

  wire       en      = ctrl[`CTRL_EN];
  wire [1:0] mode    = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire       rx_lsb  = ctrl[`CTRL_RX_LSB];
  wire       tx_ser  = ctrl[`CTRL_TX_SER];
  wire       tx_lsb  = ctrl[`CTRL_TX_LSB];
  wire       tx_all  = ctrl[`CTRL_TX_ALL];

  // ---------------- link sampling
  wire [10:0] pins;
  reg         lclk_d;

  link_sync2 #(.W(11)) u_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   ({IN_LINK_CLOCK, IN_PACKET_START, IN_BYTE_QUALIFIER, IN_DATA}),
    .q   (pins)
  );

  wire       start_s = pins[9];
  wire       qual_s  = pins[8];
  wire [7:0] din     = pins[7:0];
  wire       ledge   = pins[10] & ~lclk_d;

  always @(posedge REF_CLK) begin
    if (RST)
      lclk_d <= 1'b0;
    else
      lclk_d <= pins[10];
  end

  // ---------------- receive
  reg       active;
  reg [7:0] rx_idx;
  reg [2:0] bit_cnt;
  reg [7:0] shift;
  reg       rx_bank;
  reg [4:0] pid_hi;
  reg [7:0] pid_lo;
  reg       scrambled;
  reg       first;
  reg       take;

  wire ser = (mode == `MODE_SER_SV);

  always @* begin
    case (mode)
      `MODE_SER_SV, `MODE_PAR_SV: begin
        first = start_s & qual_s;
        take  = qual_s & (start_s | active);
      end
      `MODE_BURST: begin
        first = start_s;
        take  = start_s | active;
      end
      default: begin
        first = 1'b0;
        take  = qual_s;
      end
    endcase
  end

  wire [2:0] bc       = first ? 3'h0 : bit_cnt;
  wire [7:0] ix       = first ? 8'h00 : rx_idx;
  wire [7:0] sh_base  = first ? 8'h00 : shift;
  wire [7:0] sh_next  = rx_lsb ? {din[0], sh_base[7:1]} : {sh_base[6:0], din[0]};
  wire       step     = ledge & en & take;
  wire       wr_byte  = step & (~ser | (bc == `BIT_LAST));
  wire [7:0] byte_in  = ser ? sh_next : din;
  wire       done     = wr_byte & (ix == `PKT_LAST);
  wire [8:0] wr_addr  = rx_bank ? ({1'b0, ix} + `PKT_LEN9) : {1'b0, ix};

  always @(posedge REF_CLK) begin
    if (wr_byte)
      mem[wr_addr] <= byte_in;
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      active    <= 1'b0;
      rx_idx    <= 8'h00;
      bit_cnt   <= 3'h0;
      shift     <= 8'h00;
      pid_hi    <= 5'h00;
      pid_lo    <= 8'h00;
      scrambled <= 1'b0;
    end else if (step) begin
      if (ser) begin
        shift   <= sh_next;
        bit_cnt <= bc + 3'h1;
      end
      if (first) begin
        active <= 1'b1;
        rx_idx <= 8'h00;
      end
      if (wr_byte) begin
        if (ix == 8'h01)
          pid_hi <= byte_in[4:0];
        if (ix == 8'h02)
          pid_lo <= byte_in;
        if (ix == 8'h03)
          scrambled <= (byte_in[7:6] != 2'h0);
        if (done) begin
          rx_idx <= 8'h00;
          active <= 1'b0;
        end else begin
          rx_idx <= ix + 8'h01;
        end
      end
    end else if (!en) begin
      active  <= 1'b0;
      rx_idx  <= 8'h00;
      bit_cnt <= 3'h0;
    end
  end

  // ---------------- pid selection
  reg match;

  always @* begin
    match = 1'b0;
    for (j = 0; j < NUM_PID; j = j + 1) begin
      if (pid_tab[j][`PID_EN] && pid_tab[j][12:0] == {pid_hi, pid_lo})
        match = 1'b1;
    end
  end

  wire unit_ok = (ctrl[`CTRL_UNIT] == UNIT_ID);
  wire pass    = unit_ok & (tx_all | match);

  // ---------------- 27 MHz count
  reg [6:0]  acc;
  reg [8:0]  pcr_ext;
  reg [32:0] pcr_base;

  wire [6:0] acc_sum = acc + `TICK_ADD;
  wire       tick27  = (acc_sum >= `TICK_WRAP);

  always @(posedge REF_CLK) begin
    if (RST) begin
      acc      <= 7'h00;
      pcr_ext  <= 9'h000;
      pcr_base <= 33'h000000000;
    end else begin
      acc <= tick27 ? acc_sum - `TICK_WRAP : acc_sum;
      if (tick27) begin
        if (pcr_ext == `EXT_LAST) begin
          pcr_ext  <= 9'h000;
          pcr_base <= pcr_base + 33'h000000001;
        end else begin
          pcr_ext <= pcr_ext + 9'h001;
        end
      end
    end
  end

  // ---------------- transmit
  reg        tx_state;
  reg        tx_bank;
  reg        shown;
  reg [7:0]  tx_idx;
  reg [2:0]  tx_bit;
  reg [3:0]  div;
  reg [8:0]  ext_l;
  reg [32:0] base_l;
  reg [7:0]  pcr_byte;

  wire       out_tick  = (div == OUT_HALF - 4'h1);
  wire       fall      = out_tick & OUT_CLOCK;
  wire       last_bit  = ~tx_ser | (tx_bit == `BIT_LAST);
  wire [7:0] next_idx  = !shown ? 8'h00 : (last_bit ? tx_idx + 8'h01 : tx_idx);
  wire [2:0] next_bit  = (!shown || last_bit) ? 3'h0 : tx_bit + 3'h1;
  wire       finish    = shown & last_bit & (tx_idx == `PKT_LAST);
  wire [8:0] tx_base   = tx_bank ? `PKT_LEN9 : 9'h000;
  wire [8:0] rd_addr   = tx_base + {1'b0, next_idx};
  wire [7:0] hdr3      = mem[tx_base + 9'h003];
  wire [7:0] hdr4      = mem[tx_base + 9'h004];
  wire [7:0] hdr5      = mem[tx_base + 9'h005];
  wire       has_pcr   = hdr3[5] & (hdr4 != 8'h00) & hdr5[4];
  wire       pcr_here  = has_pcr & (next_idx >= `PCR_FIRST) & (next_idx <= `PCR_LAST);
  wire [7:0] pcr_off   = next_idx - `PCR_FIRST;
  wire [7:0] tx_byte   = pcr_here ? pcr_byte : mem[rd_addr];
  wire       tx_sbit   = tx_lsb ? tx_byte[next_bit] : tx_byte[`BIT_LAST - next_bit];
  wire       launch    = done & pass & (tx_state == TX_IDLE);

  always @* begin
    case (pcr_off[2:0])
      3'h0:    pcr_byte = base_l[32:25];
      3'h1:    pcr_byte = base_l[24:17];
      3'h2:    pcr_byte = base_l[16:9];
      3'h3:    pcr_byte = base_l[8:1];
      3'h4:    pcr_byte = {base_l[0], 6'h3F, ext_l[8]};
      default: pcr_byte = ext_l[7:0];
    endcase
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      div       <= 4'h0;
      OUT_CLOCK <= 1'b0;
    end else begin
      div <= out_tick ? 4'h0 : div + 4'h1;
      if (out_tick)
        OUT_CLOCK <= ~OUT_CLOCK;
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      tx_state           <= TX_IDLE;
      tx_bank            <= 1'b0;
      rx_bank            <= 1'b0;
      shown              <= 1'b0;
      tx_idx             <= 8'h00;
      tx_bit             <= 3'h0;
      ext_l              <= 9'h000;
      base_l             <= 33'h000000000;
      OUT_PACKET_START   <= 1'b0;
      OUT_BYTE_QUALIFIER <= 1'b0;
      OUT_DATA           <= 8'h00;
    end else begin
      if (launch) begin
        tx_bank <= rx_bank;
        rx_bank <= ~rx_bank;
      end
      case (tx_state)
        TX_IDLE: begin
          if (launch) begin
            tx_state <= TX_SEND;
            shown    <= 1'b0;
          end
          if (fall) begin
            OUT_PACKET_START   <= 1'b0;
            OUT_BYTE_QUALIFIER <= 1'b0;
          end
        end
        default: begin
          if (fall) begin
            if (finish) begin
              tx_state           <= TX_IDLE;
              shown              <= 1'b0;
              OUT_PACKET_START   <= 1'b0;
              OUT_BYTE_QUALIFIER <= 1'b0;
            end else begin
              if (!shown) begin
                ext_l  <= pcr_ext;
                base_l <= pcr_base;
              end
              shown              <= 1'b1;
              tx_idx             <= next_idx;
              tx_bit             <= next_bit;
              OUT_PACKET_START   <= !shown;
              OUT_BYTE_QUALIFIER <= 1'b1;
              OUT_DATA           <= tx_ser ? {7'h00, tx_sbit} : tx_byte;
            end
          end
        end
      endcase
    end
  end

  // ---------------- registers
  always @(posedge REF_CLK) begin
    if (RST) begin
      ctrl     <= `CTRL_RESET;
      rx_cnt   <= {`CNT_W{1'b0}};
      tx_cnt   <= {`CNT_W{1'b0}};
      drop_cnt <= {`CNT_W{1'b0}};
      scr_cnt  <= {`CNT_W{1'b0}};
      for (i = 0; i < NUM_PID; i = i + 1)
        pid_tab[i] <= {`PID_W{1'b0}};
    end else begin
      if (WR) begin
        if (ADDR == `OFF_CTRL)
          ctrl <= WDATA[`CTRL_W-1:0];
        else if (ADDR >= `OFF_PID_FIRST && ADDR <= `OFF_PID_LAST && ADDR[1:0] == 2'h0)
          pid_tab[ADDR[7:2]] <= WDATA[`PID_W-1:0];
      end
      if (done) begin
        rx_cnt <= rx_cnt + 1'b1;
        if (scrambled)
          scr_cnt <= scr_cnt + 1'b1;
        if (pass && tx_state == TX_SEND)
          drop_cnt <= drop_cnt + 1'b1;
      end
      if (fall && finish && tx_state == TX_SEND)
        tx_cnt <= tx_cnt + 1'b1;
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      if (ADDR == `OFF_CTRL)
        RDATA <= {{(32-`CTRL_W){1'b0}}, ctrl};
      else if (ADDR == `OFF_STATUS)
        RDATA <= {28'h0000000, tx_bank, rx_bank, tx_state, active};
      else if (ADDR == `OFF_RX_CNT)
        RDATA <= {16'h0000, rx_cnt};
      else if (ADDR == `OFF_TX_CNT)
        RDATA <= {16'h0000, tx_cnt};
      else if (ADDR == `OFF_DROP_CNT)
        RDATA <= {16'h0000, drop_cnt};
      else if (ADDR == `OFF_SCR_CNT)
        RDATA <= {16'h0000, scr_cnt};
      else if (ADDR >= `OFF_PID_FIRST && ADDR <= `OFF_PID_LAST && ADDR[1:0] == 2'h0)
        RDATA <= {18'h00000, pid_tab[ADDR[7:2]]};
      else
        RDATA <= 32'h00000000;
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule // ts_stream_in_out_port

// [ts_port_regs.vh]
// register map, field positions and constants of the stream port
// included by ts_stream_in_out_port.v; definitions only
`ifndef TS_PORT_REGS_VH
`define TS_PORT_REGS_VH

`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_RX_CNT    12'h008
`define OFF_TX_CNT    12'h00C
`define OFF_DROP_CNT  12'h010
`define OFF_SCR_CNT   12'h014
`define OFF_PID_FIRST 12'h100
`define OFF_PID_LAST  12'h1FC

`define CTRL_W        10
`define CTRL_RESET    10'h000
`define CTRL_EN       0
`define CTRL_MODE_LO  1
`define CTRL_MODE_HI  2
`define CTRL_RX_LSB   3
`define CTRL_TX_SER   4
`define CTRL_TX_LSB   5
`define CTRL_TX_ALL   6
`define CTRL_UNIT     7
`define CTRL_DMX_LO   8
`define CTRL_DMX_HI   9

`define MODE_SER_SV   2'h0
`define MODE_PAR_SV   2'h1
`define MODE_BURST    2'h2
`define MODE_VALID    2'h3

`define PID_W         14
`define PID_EN        13

`define PKT_LAST      8'hBB
`define PKT_LEN9      9'h0BC
`define BIT_LAST      3'h7
`define PCR_FIRST     8'h06
`define PCR_LAST      8'h0B
`define EXT_LAST      9'h12B
`define TICK_ADD      7'h1B
`define TICK_WRAP     7'h64
`define CNT_W         16

`endif

// [link_sync2.v]
// two-stage synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk; only stage two reads stage one
`timescale 1ns/100ps
module link_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] stage1;

  always @(posedge clk) begin
    if (rst) begin
      stage1 <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule // link_sync2

// [ts_link_sender.sv]
// sender model for the stream input pins of the port
// assumes the bench fills pkt before it calls send
`timescale 1ns/100ps
module ts_link_sender (
  output logic       lclk,
  output logic       start,
  output logic       qual,
  output logic [7:0] data
);
  logic [7:0] pkt [0:187];
  initial begin
    lclk = 1'b0;
    start = 1'b0;
    qual = 1'b0;
    data = 8'h00;
  end
  // pins move at the fall, held 40 ns past the rise
  task automatic beat(input logic s, input logic q, input logic [7:0] d);
    start = s;
    qual = q;
    data = d;
    #40 lclk = 1'b1;
    #40 lclk = 1'b0;
  endtask
  task automatic send(input logic [1:0] mode, input logic lsb);
    logic [7:0] d;
    // pins move off the system clock edges
    #3;
    for (int i = 0; i < 188; i++) begin
      d = pkt[i];
      if (i == 50 && mode != 2'h2)
        beat(1'b0, 1'b0, ~d);
      if (mode == 2'h0)
        for (int b = 0; b < 8; b++)
          beat(i == 0 && b == 0, 1'b1, {7'h00, lsb ? d[b] : d[7-b]});
      else
        beat(i == 0 || (mode == 2'h3 && i == 99), mode != 2'h2, d);
    end
    // released pins show the inverse, clock stands still
    start = 1'b0;
    qual = 1'b0;
    data = ~data;
  endtask
endmodule // ts_link_sender

// [ts_port_assertions.sv]
// pin and read data checks for the stream port
// assumes the default OUT_HALF of 2: one output period is 4 clocks
`timescale 1ns/100ps
module ts_port_checker #(
  parameter [3:0] OUT_HALF = 4'h2
) (
  input logic        REF_CLK,
  input logic        RST,
  input logic        RD,
  input logic [31:0] RDATA,
  input logic        OUT_CLOCK,
  input logic        OUT_PACKET_START,
  input logic        OUT_BYTE_QUALIFIER,
  input logic [7:0]  OUT_DATA
);
  logic [10:0] pkt_n;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // units sent in the current packet
  always @(posedge REF_CLK)
    if (RST)
      pkt_n <= 11'h000;
    else if ($rose(OUT_CLOCK) && OUT_BYTE_QUALIFIER)
      pkt_n <= OUT_PACKET_START ? 11'h001 : pkt_n + 11'h001;
  sequence s_start_period;
    OUT_PACKET_START [*4] ##1 !OUT_PACKET_START;
  endsequence
  a_start_qual: assert property (OUT_PACKET_START |-> OUT_BYTE_QUALIFIER)
    else $error("start without qualifier");
  a_start_once: assert property ($rose(OUT_PACKET_START) |-> s_start_period)
    else $error("start not one period long");
  a_out_on_fall: assert property ($changed({OUT_DATA, OUT_PACKET_START, OUT_BYTE_QUALIFIER}) |-> $fell(OUT_CLOCK))
    else $error("output moved off a falling clock");
  a_clk_high: assert property ($rose(OUT_CLOCK) |-> ##2 $fell(OUT_CLOCK))
    else $error("output clock high phase wrong");
  a_clk_low: assert property ($fell(OUT_CLOCK) |-> ##2 $rose(OUT_CLOCK))
    else $error("output clock low phase wrong");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside its cycle");
  a_qual_start: assert property ($rose(OUT_BYTE_QUALIFIER) |-> OUT_PACKET_START)
    else $error("qualifier rose without start");
  a_pkt_len: assert property ($fell(OUT_BYTE_QUALIFIER) |-> pkt_n == 11'h0BC || pkt_n == 11'h5E0)
    else $error("packet length wrong");
endmodule // ts_port_checker
bind ts_stream_in_out_port ts_port_checker #(.OUT_HALF(OUT_HALF)) chk_u (.REF_CLK, .RST, .RD, .RDATA,
  .OUT_CLOCK, .OUT_PACKET_START, .OUT_BYTE_QUALIFIER, .OUT_DATA);

// [tb_top.sv]
// testbench for the stream port: registers, input modes, filtering
// assumes ts_link_sender drives the link pins
`timescale 1ns/100ps
module tb_top;
  logic        ref_clk, rst, wr, rd, rd_d;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic        lclk, lstart, lqual, out_clock, out_start, out_qual;
  logic [7:0]  ldata, out_data;
  logic [7:0]  oq [$];
  logic [31:0] rq [$];
  logic [31:0] cfg [7] = '{32'h40, 32'h48, 32'h42, 32'h44, 32'h46, 32'h52, 32'h72};
  logic [31:0] cur_ctrl;
  logic [47:0] pcr_seen;
  logic [7:0]  sv;
  logic        pcr_on;
  longint      t_rel, exp_cnt;
  int          errors, checks, nb, sb, seed;
  ts_stream_in_out_port dut_u (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IN_LINK_CLOCK(lclk), .IN_PACKET_START(lstart), .IN_BYTE_QUALIFIER(lqual),
    .IN_DATA(ldata), .OUT_CLOCK(out_clock), .OUT_PACKET_START(out_start),
    .OUT_BYTE_QUALIFIER(out_qual), .OUT_DATA(out_data));
  ts_link_sender snd (.lclk(lclk), .start(lstart), .qual(lqual), .data(ldata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask
  task automatic run_pkt(input logic [31:0] ctrl, input logic [12:0] pid, input logic pass, input logic pcr);
    logic [7:0] b;
    for (int i = 0; i < 188; i++) begin
      b = 8'($random(seed));
      if (i == 0) b = 8'h47;
      if (i == 1) b = {3'h0, pid[12:8]};
      if (i == 2) b = pid[7:0];
      if (i == 3) b = pcr ? 8'h30 : 8'h10;
      if (pcr && i == 4) b = 8'hB7;
      if (pcr && i == 5) b = 8'h10;
      snd.pkt[i] = b;
      // restamped bytes are checked against the 27 MHz count instead
      if (pass && !(pcr && i >= 6 && i <= 11)) oq.push_back(b);
    end
    nb = 0;
    sb = 0;
    cur_ctrl = ctrl;
    pcr_on = pcr;
    wreg(12'h000, ctrl);
    wreg(12'h000, ctrl | 32'h1);
    snd.send(ctrl[2:1], ctrl[3]);
    for (int k = 0; k < 8000 && oq.size() != 0; k++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    chk(oq.size(), 0);
  endtask
  always @(posedge ref_clk) begin
    if (rd_d)
      chk(rdata, rq.pop_front());
    rd_d <= rd;
  end
  // receiver: one unit per rising output clock, serial bits rebuilt into bytes
  always @(posedge out_clock) begin
    if (out_qual) begin
      chk(out_start, nb % 188 == 0 && sb == 0);
      // count held at the fall two clocks back: 27 per 100 clocks since release
      if (nb % 188 == 0 && sb == 0)
        exp_cnt = (27 * (($time - t_rel) / 10 - 3)) / 100;
      if (cur_ctrl[4]) begin
        chk(out_data[7:1], 7'h00);
        sv = cur_ctrl[5] ? {out_data[0], sv[7:1]} : {sv[6:0], out_data[0]};
        sb++;
      end else begin
        sv = out_data;
        sb = 8;
      end
      if (sb == 8) begin
        sb = 0;
        if (pcr_on && nb % 188 >= 6 && nb % 188 <= 11)
          pcr_seen = {pcr_seen[39:0], sv};
        else
          chk(sv, oq.size() != 0 ? oq.pop_front() : ~sv);
        if (pcr_on && nb % 188 == 11) begin
          chk(pcr_seen[14:9], 6'h3F);
          chk(pcr_seen[8:0] < 300, 1'b1);
          chk(32'(pcr_seen[47:15] * 300 + pcr_seen[8:0]), 32'(exp_cnt));
        end
        nb++;
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #900000;
    errors++;
    give_verdict();
  end
  initial begin
    {rst, wr, rd, rd_d, addr, wdata, errors, checks, nb, sb, cur_ctrl, pcr_on} = '0;
    rst = 1'b1;
    seed = 75829;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_rel = $time;
    rreg(12'h000, 32'h0);
    wreg(12'h000, 32'hFFFFFFFE);
    rreg(12'h000, 32'h000003FE);
    rreg(12'h020, 32'h0);
    wreg(12'h100, 32'hFFFF6ABC);
    rreg(12'h100, 32'h00002ABC);
    $display("register test done");
    foreach (cfg[t]) begin
      run_pkt(cfg[t], 13'h0ABC, 1'b1, 1'b0);
      $display("mode test %0d done", t);
    end
    run_pkt(32'h42, 13'h0ABC, 1'b1, 1'b1);
    $display("pcr test done");
    rreg(12'h008, 32'h8);
    rreg(12'h00C, 32'h8);
    rreg(12'h014, 32'h0);
    rreg(12'h010, 32'h0);
    run_pkt(32'h02, 13'h0ABC, 1'b1, 1'b0);
    run_pkt(32'h02, 13'h0123, 1'b0, 1'b0);
    run_pkt(32'hC2, 13'h0ABC, 1'b0, 1'b0);
    rreg(12'h008, 32'hB);
    rreg(12'h00C, 32'h9);
    $display("filter test done");
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule // tb_top
